// ---- core/pam_pkg.sv ----
// package for the proximity / auxiliary measurement configuration block
// assumes an ahb-lite master with 32-bit data and single whole-word transfers
package pam_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register indices (byte address is four times the index)
	localparam logic [7:0] IDX_GAIN = 8'h0b;
	localparam logic [7:0] IDX_MISC = 8'h0c;
	localparam logic [7:0] IDX_IR   = 8'h0e;
	localparam logic [7:0] IDX_AUX  = 8'h0f;
	localparam logic [7:0] IDX_CTRL = 8'h00;
	localparam logic [7:0] IDX_STAT = 8'h01;

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int GAIN_LSB    = 0;
	localparam int GAIN_W      = 3;
	localparam int RANGE_BIT   = 5;
	localparam int MODE_BIT    = 2;
	localparam int GO_PROX_BIT = 0;
	localparam int GO_IR_BIT   = 1;
	localparam int GO_AUX_BIT  = 2;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_CH_LSB   = 1;
	localparam int ST_EMIT_BIT = 3;
	localparam int ST_INTG_BIT = 4;

	////////////////////////////////////////////////////////////////////////////////
	// reset values and selector codes
	localparam logic [2:0] GAIN_RST  = 3'h0;
	localparam logic       RANGE_RST = 1'b0;
	localparam logic       MODE_RST  = 1'b1;
	localparam logic [7:0] IR_SMALL  = 8'h00;
	localparam logic [7:0] IR_LARGE  = 8'h03;
	localparam logic [7:0] AUX_TEMP  = 8'h65;
	localparam logic [7:0] AUX_VDD   = 8'h75;
	localparam logic [7:0] IR_RST    = IR_SMALL;
	localparam logic [7:0] AUX_RST   = AUX_TEMP;

	////////////////////////////////////////////////////////////////////////////////
	// timing counts, in divided adc clock ticks
	localparam logic [8:0] EMIT_TICKS = 9'h008;
	localparam logic [8:0] INTG_TICKS = 9'h010;

	typedef enum logic [2:0] {RG_NONE, RG_CTRL, RG_STAT, RG_GAIN, RG_MISC, RG_IR, RG_AUX} pam_reg_t;
	typedef enum logic [1:0] {CH_NONE, CH_PROX, CH_IR, CH_AUX} pam_chan_t;
	typedef enum logic [1:0] {ST_IDLE, ST_EMIT, ST_INTG} pam_seq_t;

endpackage : pam_pkg

// ---- core/pam_meas_cfg.sv ----
// measurement configuration registers and the measurement sequencer they steer
// assumes a single ahb-lite master, word accesses only, hclk at 50 mhz
// assumes the adc front end samples adc_clk_en and adc_integrate on hclk
// assumes the host keeps the gain at or below five; the block never clamps it
// register map (byte addresses): 0x00 start, 0x04 status, 0x2c gain, 0x30 misc,
// 0x38 ambient ir select, 0x3c auxiliary select
`timescale 1ns/100ps

module pam_meas_cfg
	import pam_pkg::*;
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// adc front end
	output logic             adc_clk_en,
	output logic             adc_integrate,
	output logic             adc_high_range,
	output logic [7:0]       adc_input_sel,
	output logic [1:0]       adc_channel,
	// emitter and status
	output logic             infrared_emitter,
	output logic             meas_busy,
	output logic             meas_done
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	// one packed struct holds every flop; the comb block below builds its next value
	typedef struct packed {
		// sequencer
		pam_seq_t   st;
		pam_chan_t  ch;
		logic [6:0] div;
		logic [8:0] ticks;
		logic [2:0] run_gain;
		// configuration registers
		logic [2:0] gain;
		logic       range;
		logic       mode;
		logic [7:0] ir_sel;
		logic [7:0] aux_sel;
		// bus side
		logic       dp_wr;
		logic [7:0] dp_addr;
		logic [31:0] rdata;
		// registered outputs
		logic       tick;
		logic       emit;
		logic       intg;
		logic       hi_rng;
		logic [7:0] mux;
		logic       done;
		logic       busy;
		logic       rdy;
	} pam_state_t;

	localparam pam_state_t S_RST = '{
		st:       ST_IDLE,
		ch:       CH_NONE,
		div:      7'h00,
		ticks:    9'h000,
		run_gain: 3'h0,
		gain:     GAIN_RST,
		range:    RANGE_RST,
		mode:     MODE_RST,
		ir_sel:   IR_RST,
		aux_sel:  AUX_RST,
		dp_wr:    1'b0,
		dp_addr:  8'h00,
		rdata:    32'h0000_0000,
		tick:     1'b0,
		emit:     1'b0,
		intg:     1'b0,
		hi_rng:   1'b0,
		mux:      8'h00,
		done:     1'b0,
		busy:     1'b0,
		rdy:      1'b1
	};

	pam_state_t s_r;
	pam_state_t s_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// byte address to register
	// only the low address byte is decoded, so the map repeats every 256 bytes
	// misaligned or unmapped addresses give none: reads zero, writes ignored
	function automatic pam_reg_t reg_sel(input logic [7:0] a);
		pam_reg_t r;
		r = RG_NONE;
		if (a[1:0] == 2'b00) begin
			if (a[7:2] == IDX_CTRL[5:0]) r = RG_CTRL;
			if (a[7:2] == IDX_STAT[5:0]) r = RG_STAT;
			if (a[7:2] == IDX_GAIN[5:0]) r = RG_GAIN;
			if (a[7:2] == IDX_MISC[5:0]) r = RG_MISC;
			if (a[7:2] == IDX_IR[5:0])   r = RG_IR;
			if (a[7:2] == IDX_AUX[5:0])  r = RG_AUX;
		end
		return r;
	endfunction : reg_sel

	// last divider count for a gain code
	// gain g gives one adc tick per 2^g hclk cycles, codes six and seven included
	function automatic logic [6:0] div_last(input logic [2:0] g);
		logic [7:0] v;
		v = (8'h01 << g) - 8'h01;
		return v[6:0];
	endfunction : div_last

	// status word: busy, running channel, emitter and integrate phase
	// every other bit reads zero
	function automatic logic [31:0] stat_word(input pam_state_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[ST_BUSY_BIT] = s.busy;
		w[ST_CH_LSB +: 2] = s.ch;
		w[ST_EMIT_BIT] = s.emit;
		w[ST_INTG_BIT] = s.intg;
		return w;
	endfunction : stat_word

	////////////////////////////////////////////////////////////////////////////////
	// next state

	// defaults first: strobes fall back to zero and the bus stays ready
	always_comb begin
		logic [2:0] go;
		logic       hit;
		logic [31:0] rd;
		s_nxt = s_r;
		go = 3'b000;
		hit = 1'b0;
		rd = 32'h0000_0000;
		s_nxt.tick = 1'b0;
		s_nxt.done = 1'b0;
		s_nxt.dp_wr = 1'b0;
		s_nxt.rdy = 1'b1;

		// write data phase: only defined fields are stored
		// start bits act in this cycle only and are never stored, so no later
		// write can replay an old start
		if (s_r.dp_wr) begin
			unique case (reg_sel(s_r.dp_addr))
				RG_CTRL: begin
					go[0] = hwdata[GO_PROX_BIT];
					go[1] = hwdata[GO_IR_BIT];
					go[2] = hwdata[GO_AUX_BIT];
				end
				RG_GAIN: begin
					// bits above the field are reserved and dropped here
					s_nxt.gain = hwdata[GAIN_LSB +: GAIN_W];
				end
				RG_MISC: begin
					s_nxt.range = hwdata[RANGE_BIT];
					s_nxt.mode = hwdata[MODE_BIT];
				end
				RG_IR: begin
					s_nxt.ir_sel = hwdata[7:0];
				end
				RG_AUX: begin
					s_nxt.aux_sel = hwdata[7:0];
				end
				RG_NONE, RG_STAT: begin
				end
			endcase
		end

		// address phase: capture writes, prepare read data
		// read data come from the registers as they stand at the address edge,
		// so a read right behind a write to the same register sees the old value
		// hrdata then stands until the next accepted address phase
		hit = hsel && htrans[1] && hready;
		if (hit) begin
			s_nxt.dp_wr = hwrite;
			s_nxt.dp_addr = haddr[7:0];
			unique case (reg_sel(haddr[7:0]))
				RG_GAIN: begin
					rd[GAIN_LSB +: GAIN_W] = s_r.gain;
				end
				RG_MISC: begin
					rd[RANGE_BIT] = s_r.range;
					rd[MODE_BIT] = s_r.mode;
				end
				RG_IR: begin
					rd[7:0] = s_r.ir_sel;
				end
				RG_AUX: begin
					rd[7:0] = s_r.aux_sel;
				end
				RG_STAT: begin
					rd = stat_word(s_r);
				end
				RG_NONE, RG_CTRL: begin
				end
			endcase
			s_nxt.rdata = rd;
		end

		// measurement sequencer
		// gain and range are latched at the start, so a write during a run only
		// affects the next measurement; starts while busy are dropped
		unique case (s_r.st)
			ST_IDLE: begin
				// counters restart for every measurement
				s_nxt.div = 7'h00;
				s_nxt.ticks = 9'h000;
				// a start that arrives while busy never reaches this branch
				if (go != 3'b000) begin
					s_nxt.intg = 1'b1;
					s_nxt.st = ST_INTG;
					// proximity wins over ambient ir, ambient ir over auxiliary
					if (go[0]) begin
						s_nxt.ch = CH_PROX;
						s_nxt.mux = 8'h00;
						s_nxt.run_gain = s_r.gain;
						s_nxt.hi_rng = s_r.range;
						if (s_r.mode) begin
							s_nxt.st = ST_EMIT;
							s_nxt.emit = 1'b1;
							s_nxt.intg = 1'b0;
						end
					end else if (go[1]) begin
						s_nxt.ch = CH_IR;
						s_nxt.mux = s_r.ir_sel;
						s_nxt.run_gain = 3'h0;
						s_nxt.hi_rng = 1'b0;
					end else begin
						s_nxt.ch = CH_AUX;
						s_nxt.mux = s_r.aux_sel;
						s_nxt.run_gain = 3'h0;
						s_nxt.hi_rng = 1'b0;
					end
				end
			end
			ST_EMIT, ST_INTG: begin
				// divided adc clock, one tick per 2^gain cycles
				if (s_r.div == div_last(s_r.run_gain)) begin
					s_nxt.div = 7'h00;
					s_nxt.tick = 1'b1;
					s_nxt.ticks = s_r.ticks + 9'h001;
				end else begin
					s_nxt.div = s_r.div + 7'h01;
				end
				// emitter pulse in ticks, so it scales with gain
				// integrate rises on the same edge at which the emitter falls
				if (s_r.st == ST_EMIT && s_nxt.tick
						&& s_r.ticks == EMIT_TICKS - 9'h001) begin
					s_nxt.st = ST_INTG;
					s_nxt.emit = 1'b0;
					s_nxt.intg = 1'b1;
					s_nxt.ticks = 9'h000;
				end
				// integration in ticks, so it scales with gain on proximity runs; ambient ir and auxiliary runs use gain zero
				// done pulses for one cycle as busy falls
				if (s_r.st == ST_INTG && s_nxt.tick
						&& s_r.ticks == INTG_TICKS - 9'h001) begin
					s_nxt.st = ST_IDLE;
					s_nxt.intg = 1'b0;
					s_nxt.hi_rng = 1'b0;
					s_nxt.ch = CH_NONE;
					s_nxt.ticks = 9'h000;
					s_nxt.done = 1'b1;
				end
			end
			default: begin
				// the unused state code falls back to idle
				s_nxt.st = ST_IDLE;
			end
		endcase

		// emitter guard: only a proximity run in normal mode may drive the emitter,
		// so raw adc mode and the other channels never light it
		if (s_nxt.ch != CH_PROX) begin
			s_nxt.emit = 1'b0;
		end
		if (s_r.st == ST_IDLE && !s_r.mode) begin
			s_nxt.emit = 1'b0;
		end

		// busy is registered, so the status bit and the output need no decode
		// it follows the state that the register is about to take
		s_nxt.busy = (s_nxt.st != ST_IDLE);
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	// asynchronous reset loads constants only: the register defaults
	// and an idle sequencer with the bus ready
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= S_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register except hresp, which is tied low

	// bus side: always ready, and the answer is always okay
	// unmapped and reserved accesses are simply ignored, never refused
	assign hreadyout        = s_r.rdy;
	assign hresp            = 1'b0;
	assign hrdata           = s_r.rdata;

	// adc front end
	assign adc_clk_en       = s_r.tick;
	assign adc_integrate    = s_r.intg;
	assign adc_high_range   = s_r.hi_rng;
	assign adc_input_sel    = s_r.mux;
	assign adc_channel      = s_r.ch;

	// emitter and status
	assign infrared_emitter = s_r.emit;
	assign meas_busy        = s_r.busy;
	assign meas_done        = s_r.done;

endmodule : pam_meas_cfg

// ---- sim/pam_chk.sv ----
// checker: sequencer and bus relations seen at the block's ports
// assumes bind to pam_meas_cfg, one hclk domain, hresetn async low
`timescale 1ns/100ps
module pam_chk
	import pam_pkg::*;
(
	// clock and reset
	input wire logic       hclk,
	input wire logic       hresetn,
	// watched outputs
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       adc_clk_en,
	input wire logic       adc_integrate,
	input wire logic       adc_high_range,
	input wire logic [1:0] adc_channel,
	input wire logic       infrared_emitter,
	input wire logic       meas_busy,
	input wire logic       meas_done
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////////////////////////////////////////////
	// bus answer is zero wait and okay
	bus_okay_a: assert property (hresp == 1'b0 && hreadyout == 1'b1)
		else $error("bus answer not okay or not ready");
	// emitter phase belongs to a running proximity measurement
	emit_prox_a: assert property (
		infrared_emitter |-> !adc_integrate && meas_busy && adc_channel == CH_PROX)
		else $error("emitter outside a proximity emit phase");
	emit_start_a: assert property ($rose(infrared_emitter) |-> $rose(meas_busy))
		else $error("emitter did not rise at measurement start");
	emit_intg_a: assert property ($fell(infrared_emitter) |-> adc_integrate)
		else $error("integration did not follow the emit phase");
	intg_done_a: assert property ($fell(adc_integrate) |-> meas_done && !meas_busy)
		else $error("integration end without done");
	done_pulse_a: assert property (meas_done |=> !meas_done)
		else $error("done longer than one cycle");
	range_prox_a: assert property (adc_high_range |-> adc_channel == CH_PROX)
		else $error("high range outside proximity");
	tick_rate_a: assert property (
		adc_integrate && adc_channel != CH_PROX |=> adc_clk_en)
		else $error("undivided tick missing");
	idle_quiet_a: assert property (
		!meas_busy |-> adc_channel == CH_NONE && !adc_integrate && !infrared_emitter)
		else $error("sequencer active while idle");
	// main scenarios
	cover property ($rose(infrared_emitter));
	cover property ($rose(adc_high_range));
	cover property (adc_integrate && adc_channel == CH_AUX);
endmodule : pam_chk
bind pam_meas_cfg pam_chk u_pam_chk (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .adc_clk_en(adc_clk_en),
	.adc_integrate(adc_integrate), .adc_high_range(adc_high_range),
	.adc_channel(adc_channel), .infrared_emitter(infrared_emitter),
	.meas_busy(meas_busy), .meas_done(meas_done));

// ---- sim/pam_adc_model.sv ----
// adc front-end model: measures the phases of each measurement
// assumes it watches the sequencer outputs on hclk; counts restart per start
`timescale 1ns/100ps
module pam_adc_model (
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// sequencer outputs
	input  wire logic       adc_clk_en,
	input  wire logic       adc_integrate,
	input  wire logic       adc_high_range,
	input  wire logic [7:0] adc_input_sel,
	input  wire logic [1:0] adc_channel,
	input  wire logic       infrared_emitter,
	input  wire logic       meas_busy,
	// last measurement seen
	output logic [15:0]     emit_cyc,
	output logic [15:0]     emit_tck,
	output logic [15:0]     intg_cyc,
	output logic            range_seen,
	output logic [7:0]      sel_seen,
	output logic [1:0]      chan_seen
);
	logic busy_q;
	logic emit_q;
	logic first;
	assign first = meas_busy && !busy_q;
	// counts restart as the sequencer leaves idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_q <= 1'b0;
			emit_q <= 1'b0;
		end else begin
			busy_q <= meas_busy;
			emit_q <= infrared_emitter;
			emit_cyc <= (first ? 16'h0 : emit_cyc) + 16'(infrared_emitter);
			// a tick strobe follows its divided period by one cycle
			emit_tck <= (first ? 16'h0 : emit_tck) + 16'(emit_q && adc_clk_en);
			intg_cyc <= (first ? 16'h0 : intg_cyc) + 16'(adc_integrate);
			range_seen <= (first ? 1'b0 : range_seen) | adc_high_range;
			if (adc_integrate) begin
				sel_seen <= adc_input_sel;
				chan_seen <= adc_channel;
			end
		end
	end
endmodule : pam_adc_model

// ---- sim/test_pam_meas_cfg.sv ----
// testbench: register access over ahb-lite and measurement runs
// assumes pam_meas_cfg alone on the bus, hready fed back from hreadyout
`timescale 1ns/100ps
module test_pam_meas_cfg
	import pam_pkg::*;
;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [2:0]  hsize = 3'h2;
	logic        hready;
	logic        hreadyout, hresp, adc_clk_en, adc_integrate, adc_high_range;
	logic        infrared_emitter, meas_busy, meas_done, range_seen;
	logic [31:0] hrdata;
	logic [7:0]  adc_input_sel, sel_seen;
	logic [1:0]  adc_channel, chan_seen;
	logic [15:0] emit_cyc, emit_tck, intg_cyc;
	int          err_total = 0;
	int          n_compared = 0;
	assign hready = hreadyout;
	// 50 mhz clock
	always #10 hclk = ~hclk;
	pam_meas_cfg u_pam_meas_cfg (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .adc_clk_en(adc_clk_en),
		.adc_integrate(adc_integrate), .adc_high_range(adc_high_range),
		.adc_input_sel(adc_input_sel), .adc_channel(adc_channel),
		.infrared_emitter(infrared_emitter), .meas_busy(meas_busy), .meas_done(meas_done));
	pam_adc_model u_pam_adc_model (.hclk(hclk), .hresetn(hresetn), .adc_clk_en(adc_clk_en),
		.adc_integrate(adc_integrate), .adc_high_range(adc_high_range),
		.adc_input_sel(adc_input_sel), .adc_channel(adc_channel),
		.infrared_emitter(infrared_emitter), .meas_busy(meas_busy), .emit_cyc(emit_cyc),
		.emit_tck(emit_tck), .intg_cyc(intg_cyc), .range_seen(range_seen),
		.sel_seen(sel_seen), .chan_seen(chan_seen));
	////////////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// one single word transfer; byte address is four times the index
	task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {22'h0, idx, 2'b00};
		hwrite <= wr;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
		// hsel stays high between calls; htrans idle marks the gap
	endtask : bus
	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		logic [31:0] rd;
		bus(idx, 1'b1, wd, rd);
	endtask : wr
	task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] rd;
		bus(idx, 1'b0, 32'h0, rd);
		chk(nm, rd, exp);
	endtask : rdc
	// start a measurement and wait for its done pulse
	task automatic meas(input logic [31:0] ctrl);
		int n;
		wr(IDX_CTRL, ctrl);
		for (n = 0; n < 5000; n++) begin
			@(negedge hclk);
			if (meas_done === 1'b1) break;
		end
		chk("done", {31'h0, meas_done}, 32'h1);
		@(posedge hclk);
	endtask : meas
	// selector code routed during integration
	task automatic mux(input logic [7:0] idx, input logic [7:0] code, input logic [31:0] ctrl,
		input logic [1:0] ch);
		wr(idx, {24'h0, code});
		meas(ctrl);
		chk("sel", {24'h0, sel_seen}, {24'h0, code});
		chk("chan", {30'h0, chan_seen}, {30'h0, ch});
	endtask : mux
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////////////////////
	// watchdog well beyond the expected run
	initial begin
		#1000000;
		err_total++;
		end_sim();
	end
	// main sequence
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc("gain rst", IDX_GAIN, 32'h0);
		rdc("misc rst", IDX_MISC, 32'h4);
		rdc("ir rst", IDX_IR, 32'h0);
		rdc("aux rst", IDX_AUX, 32'h65);
		rdc("stat idle", IDX_STAT, 32'h0);
		wr(IDX_GAIN, 32'hffff_fffa);
		rdc("gain rsv", IDX_GAIN, 32'h2);
		wr(IDX_MISC, 32'hffff_ffff);
		rdc("misc rsv", IDX_MISC, 32'h24);
		wr(8'h02, 32'hffff_ffff);
		rdc("unmapped", 8'h02, 32'h0);
		wr(IDX_MISC, 32'h4);
		// host software keeps the gain at or below five
		for (int g = 0; g < 6; g++) begin
			wr(IDX_GAIN, 32'(g));
			meas(32'h1);
			chk("emit cyc", 32'(emit_cyc), 32'(8 << g));
			chk("emit tck", 32'(emit_tck), 32'h8);
			chk("intg cyc", 32'(intg_cyc), 32'(16 << g));
			chk("range", {31'h0, range_seen}, 32'h0);
		end
		// raw mode with high range: no emitter, range flagged
		wr(IDX_GAIN, 32'h1);
		wr(IDX_MISC, 32'h20);
		wr(IDX_CTRL, 32'h1);
		rdc("raw stat", IDX_STAT, 32'h13);
		// this second start falls while busy and must be dropped
		meas(32'h1);
		chk("raw emit", 32'(emit_cyc), 32'h0);
		chk("raw intg", 32'(intg_cyc), 32'h20);
		chk("hi range", {31'h0, range_seen}, 32'h1);
		mux(IDX_IR, IR_LARGE, 32'h2, 2'h2);
		mux(IDX_IR, IR_SMALL, 32'h2, 2'h2);
		mux(IDX_AUX, AUX_VDD, 32'h4, 2'h3);
		mux(IDX_AUX, AUX_TEMP, 32'h4, 2'h3);
		end_sim();
	end
endmodule : test_pam_meas_cfg
